// file: verilog/mdm_unit.sv
// Multiply, divide and multiply-accumulate coprocessor top level
`timescale 1ns/1ps
`default_nettype none
`include "mdm_regs.svh"
module mdm_unit
  import mdm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire mdm_op_t     op,
  input  wire logic        sgn,
  input  wire logic [31:0] opnd_a,
  input  wire logic [31:0] opnd_b,
  input  wire logic        acc_load,
  input  wire logic [31:0] acc_load_val,
  input  wire logic        flag_clr,
  output logic [31:0]      result_lo_q,
  output logic [31:0]      result_hi_q,
  output logic [31:0]      acc_q,
  output logic             busy_q,
  output logic             range_flag_q,
  output logic             range_dir_q,
  output logic             irq_q
);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  mdm_state_t  state_q;
  logic [5:0]  cnt_q;
  logic [31:0] prod_q;
  logic [31:0] prod_c;
  logic        sgn_q;
  logic        div_busy;
  logic        div_done;
  logic [31:0] div_quot;
  logic [31:0] div_rem;
  logic [32:0] sum_u;
  logic [32:0] sum_s;
  logic        ovf_c;
  logic        unf_c;
  logic        mac_step;

  // Operands arrive from logic on core_clk, so no synchroniser
  wire go = ce && start && !busy_q && (op != MDM_OP_NONE);

  always_comb
  begin
    // Operands widened first, so the product keeps all 32 bits
    if (sgn)
      prod_c = $signed({{16{opnd_a[15]}}, opnd_a[15:0]})
             * $signed({{16{opnd_b[15]}}, opnd_b[15:0]});
    else
      prod_c = {16'h0000, opnd_a[15:0]} * {16'h0000, opnd_b[15:0]};
  end

  // State and cycle counter
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= MDM_ST_IDLE;
      cnt_q   <= 6'd0;
      busy_q  <= 1'b0;
      sgn_q   <= 1'b0;
      prod_q  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      case (state_q)
        MDM_ST_IDLE:
        begin
          if (go)
          begin
            cnt_q  <= 6'd1;
            sgn_q  <= sgn;
            prod_q <= prod_c;
            case (op)
              MDM_OP_MUL: state_q <= MDM_ST_IDLE;
              MDM_OP_DIV:
              begin
                state_q <= MDM_ST_DIV;
                busy_q  <= 1'b1;
              end
              MDM_OP_MAC:
              begin
                state_q <= MDM_ST_MAC;
                busy_q  <= 1'b1;
              end
              default: state_q <= MDM_ST_IDLE;
            endcase
          end
        end
        MDM_ST_MAC:
        begin
          if (cnt_q == `MDM_MAC_CYCLES - 6'd1)
          begin
            state_q <= MDM_ST_IDLE;
            busy_q  <= 1'b0;
          end
          cnt_q <= cnt_q + 6'd1;
        end
        MDM_ST_DIV:
        begin
          if (div_done)
          begin
            state_q <= MDM_ST_IDLE;
            busy_q  <= 1'b0;
          end
          cnt_q <= cnt_q + 6'd1;
        end
        default:
        begin
          state_q <= MDM_ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // divide sequencing
  mdm_div_core u_div
  (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .start    (go && op == MDM_OP_DIV),
    .dividend (opnd_a),
    .divisor  (opnd_b),
    .busy     (div_busy),
    .done     (div_done),
    .quot     (div_quot),
    .rem      (div_rem)
  );

  // ----------------------------------------
  // Results
  // ----------------------------------------
  // Product register; divide leaves quotient low, remainder high
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      result_lo_q <= 32'h0000_0000;
      result_hi_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (go && op == MDM_OP_MUL)
        result_lo_q <= prod_c;
      else if (div_done)
      begin
        result_lo_q <= div_quot;
        result_hi_q <= div_rem;
      end
    end
  end

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  assign mac_step = (state_q == MDM_ST_MAC) && (cnt_q == `MDM_MAC_CYCLES - 6'd1);

  // Wraps on range exit; the flag tells software what happened
  always_comb
  begin
    sum_u = {1'b0, acc_q} + {1'b0, prod_q};
    sum_s = {acc_q[31], acc_q} + {prod_q[31], prod_q};
    if (sgn_q)
    begin
      ovf_c = (sum_s[32:31] == 2'b01);
      unf_c = (sum_s[32:31] == 2'b10);
    end
    else
    begin
      ovf_c = sum_u[32];
      unf_c = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      acc_q <= `MDM_ACC_RESET;
    else if (ce)
    begin
      if (mac_step)
        acc_q <= sum_u[31:0];
      else if (acc_load && !busy_q)
        acc_q <= acc_load_val;
    end
  end

  // sticky range flag, set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      range_flag_q <= 1'b0;
      range_dir_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (mac_step && (ovf_c || unf_c))
      begin
        range_flag_q <= 1'b1;
        range_dir_q  <= unf_c;
      end
      else if (flag_clr)
        range_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // one-clock request on divide done or range exit
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else if (ce)
      irq_q <= div_done || (mac_step && (ovf_c || unf_c));
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_mul_one_clk: assert property (@(posedge core_clk) disable iff (rst)
    (go && op == MDM_OP_MUL) |=> (result_lo_q == $past(prod_c)))
    else $error("product not ready after one clock");

  // Cycle counter runs with the divider, so done must meet its last count
  a_div_sixteen: assert property (@(posedge core_clk) disable iff (rst)
    (ce && state_q == MDM_ST_DIV) |-> (div_done == (cnt_q == `MDM_DIV_CYCLES - 6'd1)))
    else $error("divide not done on its sixteenth clock");

  a_mac_two_clk: assert property (@(posedge core_clk) disable iff (rst)
    (go && op == MDM_OP_MAC) ##1 ce |=> !busy_q && acc_q == $past(acc_q) + $past(prod_q))
    else $error("accumulate not done in two clocks");

  a_irq_no_mul: assert property (@(posedge core_clk) disable iff (rst)
    (ce && state_q == MDM_ST_IDLE && !div_done) |=> !irq_q)
    else $error("request without divide or range event");

  a_irq_range: assert property (@(posedge core_clk) disable iff (rst)
    (ce && mac_step && (ovf_c || unf_c)) |=> irq_q && range_flag_q)
    else $error("range exit without request");

  a_irq_div: assert property (@(posedge core_clk) disable iff (rst)
    (ce && div_done) |=> irq_q)
    else $error("divide done without request");

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
    (range_flag_q && !flag_clr) |=> range_flag_q)
    else $error("range flag dropped without clear");

  a_busy_guard: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == MDM_ST_DIV) |-> (div_busy && busy_q))
    else $error("divider idle during divide");
endmodule
`default_nettype wire

// file: inc/mdm_regs.svh
// Timing counts and reset values for the multiply/divide/accumulate unit
`ifndef MDM_REGS_SVH
`define MDM_REGS_SVH
`define MDM_MUL_CYCLES   6'd1
`define MDM_DIV_CYCLES   6'd16
`define MDM_MAC_CYCLES   6'd2
`define MDM_ACC_RESET    32'h0000_0000
`define MDM_DIV_STEPS    6'd32
`endif

// file: inc/mdm_pkg.sv
// Types shared by the multiply/divide/accumulate unit
package mdm_pkg;
  typedef enum logic [1:0] {
    MDM_OP_MUL,
    MDM_OP_DIV,
    MDM_OP_MAC,
    MDM_OP_NONE
  } mdm_op_t;
  typedef enum logic [1:0] {
    MDM_ST_IDLE,
    MDM_ST_MUL,
    MDM_ST_DIV,
    MDM_ST_MAC
  } mdm_state_t;
endpackage

// file: verilog/mdm_div_core.sv
// Restoring divider, two quotient bits per clock, sixteen clocks for 32/32
`timescale 1ns/1ps
`default_nettype none
`include "mdm_regs.svh"
module mdm_div_core
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             busy,
  output logic             done,
  output logic [31:0]      quot,
  output logic [31:0]      rem
);
  // ----------------------------------------
  // Two-step radix-2 iteration
  // ----------------------------------------
  logic [32:0] r1;
  logic [32:0] r2;
  logic [31:0] q1;
  logic [31:0] q2;
  logic [32:0] t1;
  logic [32:0] t2;
  logic [31:0] src_rem;
  logic [31:0] src_quot;
  logic [31:0] src_dvs;
  logic [31:0] rem_q;
  logic [31:0] quot_q;
  logic [31:0] dvs_q;
  logic [5:0]  step_q;

  // First step works straight on the operands, so the last one ends clock sixteen
  // Divisor zero gives all-ones quotient and dividend as remainder
  always_comb
  begin
    src_rem  = start ? 32'h0000_0000 : rem_q;
    src_quot = start ? dividend : quot_q;
    src_dvs  = start ? divisor : dvs_q;
    t1 = {src_rem, src_quot[31]} - {1'b0, src_dvs};
    r1 = t1[32] ? {src_rem, src_quot[31]} : t1;
    q1 = {src_quot[30:0], ~t1[32]};
    t2 = {r1[31:0], q1[31]} - {1'b0, src_dvs};
    r2 = t2[32] ? {r1[31:0], q1[31]} : t2;
    q2 = {q1[30:0], ~t2[32]};
  end

  // Result ports show the step in flight; only valid while done is high
  always_comb
  begin
    quot = q2;
    rem  = r2[31:0];
    done = busy && (step_q + 6'd2 == `MDM_DIV_STEPS);
  end

  // Step counter and partial results
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      busy   <= 1'b0;
      quot_q <= 32'h0000_0000;
      rem_q  <= 32'h0000_0000;
      dvs_q  <= 32'h0000_0000;
      step_q <= 6'd0;
    end
    else if (ce)
    begin
      if (start)
      begin
        busy   <= 1'b1;
        quot_q <= q2;
        rem_q  <= r2[31:0];
        dvs_q  <= divisor;
        step_q <= 6'd2;
      end
      else if (busy)
      begin
        quot_q <= q2;
        rem_q  <= r2[31:0];
        step_q <= step_q + 6'd2;
        if (done)
          busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/mdm_cpu_model.sv
// CPU-side model that issues unit operations and waits out their counts
`timescale 1ns/1ps
`default_nettype none
module mdm_cpu_model
  import mdm_pkg::*;
(
  input  wire logic        core_clk,
  output logic             start,
  output mdm_op_t          op,
  output logic             sgn,
  output logic [31:0]      opnd_a,
  output logic [31:0]      opnd_b
);
  // Quiet bus at time zero
  initial
  begin
    start = 1'b0;
    op = MDM_OP_NONE;
    sgn = 1'b0;
    opnd_a = 32'h0;
    opnd_b = 32'h0;
  end
  // one start strobe with its operands, held for one edge
  task automatic strobe(input mdm_op_t o, input logic s, input logic [31:0] a,
                        input logic [31:0] b);
    @(posedge core_clk);
    start <= 1'b1;
    op <= o;
    sgn <= s;
    opnd_a <= a;
    opnd_b <= b;
    @(posedge core_clk);
    start <= 1'b0;
    op <= MDM_OP_NONE;
    opnd_a <= ~a; // Stale operands inverted, so late sampling shows
    opnd_b <= ~b;
  endtask
  // start, then read once the count has run from the start cycle
  task automatic issue(input mdm_op_t o, input logic s, input logic [31:0] a,
                       input logic [31:0] b);
    int n;
    n = (o == MDM_OP_DIV) ? 16 : ((o == MDM_OP_MAC) ? 2 : 1);
    strobe(o, s, a, b);
    repeat (n - 1) @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the multiply/divide/accumulate unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mdm_pkg::*;
  typedef struct packed {mdm_op_t op; logic sgn; logic [31:0] a; logic [31:0] b;} mdm_row_t;
  // ----------------------------------------
  // Signals and stimulus table
  // ----------------------------------------
  logic        core_clk, rst, ce, acc_load, flag_clr, start, sgn;
  logic        busy_q, range_flag_q, range_dir_q, irq_q, e_flag;
  logic [31:0] acc_load_val, opnd_a, opnd_b, result_lo_q, result_hi_q, acc_q, e_acc;
  mdm_op_t     op;
  int          n_errors = 0;
  int          compares = 0;
  mdm_row_t    rows [6] = '{'{MDM_OP_MUL, 1'b0, 32'h5a5a_ffff, 32'hffff},
                            '{MDM_OP_MUL, 1'b1, 32'hffff, 32'h2},
                            '{MDM_OP_DIV, 1'b0, 32'h64, 32'h7},
                            '{MDM_OP_DIV, 1'b0, 32'h1234_5678, 32'h0},
                            '{MDM_OP_MAC, 1'b0, 32'h3, 32'h4},
                            '{MDM_OP_MAC, 1'b1, 32'hffff, 32'h1}};
  // Free-running 250 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  mdm_unit DUT (.core_clk(core_clk), .rst(rst), .ce(ce), .start(start), .op(op),
    .sgn(sgn), .opnd_a(opnd_a), .opnd_b(opnd_b), .acc_load(acc_load),
    .acc_load_val(acc_load_val), .flag_clr(flag_clr), .result_lo_q(result_lo_q),
    .result_hi_q(result_hi_q), .acc_q(acc_q), .busy_q(busy_q),
    .range_flag_q(range_flag_q), .range_dir_q(range_dir_q), .irq_q(irq_q));
  mdm_cpu_model u_cpu (.core_clk(core_clk), .start(start), .op(op), .sgn(sgn),
    .opnd_a(opnd_a), .opnd_b(opnd_b));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic conclude;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Accumulator preload while idle
  task automatic load(input logic [31:0] v);
    @(posedge core_clk);
    acc_load <= 1'b1;
    acc_load_val <= v;
    @(posedge core_clk);
    acc_load <= 1'b0;
    #1;
    e_acc = v;
    chk(acc_q, v);
  endtask
  // One operation, expectations reckoned from the operands
  task automatic run(input mdm_row_t r);
    logic [31:0] p;
    logic [32:0] t;
    logic        of;
    if (r.sgn)
      p = $signed(r.a[15:0]) * $signed(r.b[15:0]);
    else
      p = r.a[15:0] * r.b[15:0];
    t = {r.sgn & e_acc[31], e_acc} + {r.sgn & p[31], p};
    of = (r.op == MDM_OP_MAC) & (r.sgn ? t[32] ^ t[31] : t[32]);
    u_cpu.issue(r.op, r.sgn, r.a, r.b);
    chk(irq_q, (r.op == MDM_OP_DIV) | of);
    if (r.op == MDM_OP_MUL)
      chk(result_lo_q, p);
    else if (r.op == MDM_OP_DIV)
    begin
      chk(result_lo_q, (r.b == 0) ? 32'hffff_ffff : r.a / r.b);
      chk(result_hi_q, (r.b == 0) ? r.a : r.a % r.b);
      chk(busy_q, 1'b0);
    end
    else
    begin
      e_acc = t[31:0];
      e_flag = e_flag | of;
      chk(acc_q, e_acc);
      chk(busy_q, 1'b0);
      chk(range_flag_q, e_flag);
      if (of)
        chk(range_dir_q, r.sgn & t[32]);
    end
    @(posedge core_clk);
    #1;
    chk(irq_q, 1'b0);
  endtask
  // Main sequence: reset, table, then range edges
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    acc_load = 1'b0;
    acc_load_val = 32'h0;
    flag_clr = 1'b0;
    e_acc = 32'h0;
    e_flag = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(acc_q, 32'h0);
    chk(irq_q | busy_q | range_flag_q, 1'b0);
    foreach (rows[i]) run(rows[i]);
    load(32'h7fff_ffff);
    run(mdm_row_t'{MDM_OP_MAC, 1'b1, 32'h1, 32'h1});
    load(32'h8000_0000);
    run(mdm_row_t'{MDM_OP_MAC, 1'b1, 32'hffff, 32'h1});
    load(32'hffff_ffff);
    run(mdm_row_t'{MDM_OP_MAC, 1'b0, 32'h1, 32'h1});
    @(posedge core_clk);
    flag_clr <= 1'b1;
    @(posedge core_clk);
    flag_clr <= 1'b0;
    #1;
    chk(range_flag_q, 1'b0);
    // Range set and clear on one edge; preload refused while busy
    load(32'h7fff_ffff);
    u_cpu.strobe(MDM_OP_MAC, 1'b1, 32'h1, 32'h1);
    flag_clr <= 1'b1;
    acc_load <= 1'b1;
    acc_load_val <= 32'h0000_1234;
    @(posedge core_clk);
    flag_clr <= 1'b0;
    acc_load <= 1'b0;
    #1;
    chk(range_flag_q, 1'b1);
    chk(acc_q, 32'h8000_0000);
    chk(irq_q, 1'b1);
    // Start refused while a divide runs
    u_cpu.strobe(MDM_OP_DIV, 1'b0, 32'h0000_03e8, 32'h3);
    u_cpu.strobe(MDM_OP_MUL, 1'b0, 32'h7, 32'h7);
    #1;
    chk(busy_q, 1'b1);
    repeat (13) @(posedge core_clk);
    #1;
    chk(result_lo_q, 32'h0000_014d);
    chk(result_hi_q, 32'h1);
    chk(irq_q, 1'b1);
    // Clock enable low freezes a divide in flight
    u_cpu.strobe(MDM_OP_DIV, 1'b0, 32'h0000_00ff, 32'h10);
    ce <= 1'b0;
    repeat (5) @(posedge core_clk);
    ce <= 1'b1;
    repeat (14) @(posedge core_clk);
    #1;
    chk(busy_q, 1'b1);
    chk(result_lo_q, 32'h0000_014d);
    @(posedge core_clk);
    #1;
    chk(result_lo_q, 32'hf);
    chk(result_hi_q, 32'hf);
    chk(irq_q, 1'b1);
    // Second reset in mid-run, then the unit works again
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(acc_q, 32'h0);
    chk(range_flag_q | irq_q | busy_q, 1'b0);
    chk(result_lo_q | result_hi_q, 32'h0);
    e_acc = 32'h0;
    e_flag = 1'b0;
    u_cpu.strobe(MDM_OP_NONE, 1'b0, 32'h9, 32'h9);
    #1;
    chk(busy_q | irq_q, 1'b0);
    chk(result_lo_q, 32'h0);
    run(rows[4]);
    conclude;
  end
  // Watchdog sized well past the whole sequence
  initial
  begin
    #20000;
    n_errors++;
    conclude;
  end
endmodule
`default_nettype wire
